// file: rtl/pbm_pkg.sv
// Function
// - Shared-strobe scheme: direction on read pin, enable strobe on write pin.
// - Separate-strobe scheme: independent read and write strobes on own pins.
// - Byte-enable pin is I/O in 8-bit mode, byte strobe in 16-bit mode.
// - Chip-select field maps top two pins to address or chip selects.
// - Address-mux field frees address pins and places latch strobes on pins 0/1.
// - Data pins carry low address (part or full mux), high address (full mux only), then one data byte per bus cycle, low byte first.
// - Trigger read drives address, pulses read strobe, captures byte into low byte.
// - 16-bit trigger read does two bus reads, low then high byte.
// - Trigger read returns the low data-in byte left by the previous read or write.
// - Trigger write drives address, puts low byte on data pins, pulses write.
// - 16-bit trigger write does two bus writes, low then high byte.
// - Busy is high for all but the final cycle of an operation.
// - Busy is kept only in master mode.
// - Trigger access while busy is ignored and starts nothing.
// - With interrupt enabled, raise interrupt at each completed bus cycle.
// - Each bus cycle takes one, two or three cycles by mux mode.
// - Upper address bits used as chip selects read as zero in high phase.
// - Auto step updates address once after each operation completes.
package pbm_pkg;
    localparam logic [1:0] MUX_NONE    = 2'h0;
    localparam logic [1:0] MUX_PART    = 2'h1;
    localparam logic [1:0] MUX_FULL    = 2'h2;
    localparam logic [1:0] CS_NONE     = 2'h0;
    localparam logic [1:0] CS_ONE      = 2'h1;
    localparam logic [1:0] CS_TWO      = 2'h2;
    localparam logic [1:0] STEP_NONE   = 2'h0;
    localparam logic [1:0] STEP_INC    = 2'h1;
    localparam logic [1:0] STEP_DEC    = 2'h2;
    localparam int         FIFO_DEPTH  = 16;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    typedef enum logic [3:0] {
        PBM_IDLE  = 4'h1,
        PBM_ALOW  = 4'h2,
        PBM_AHIGH = 4'h4,
        PBM_DATA  = 4'h8
    } pbm_state_t;

    typedef struct packed {
        logic       masterMode;
        logic       sharedStrobe;
        logic       wideDataSelect;
        logic [1:0] addrMuxSelect;
        logic [1:0] chipSelectFunction;
        logic [1:0] addrStepSelect;
        logic       intEnable;
    } pbm_cfg_t;

    typedef struct packed {
        logic [7:0]  dataOut;
        logic        dataOe;
        logic [15:0] addressPins;
        logic [15:0] addressOe;
        logic        readStrobePin;
        logic        writeStrobePin;
        logic        byteEnableStrobe;
        logic        byteEnableOe;
    } pbm_pins_t;

    typedef struct packed {
        logic       write;
        logic [7:0] data;
    } pbm_req_t;
endpackage : pbm_pkg

// file: rtl/pbm_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module pbm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
    } pbm_fifo_st_t;
    pbm_fifo_st_t state_q, state_d;
    logic push, pop;

    assign inReady  = state_q.count != (AW+1)'(DEPTH);
    assign outValid = state_q.count != '0;
    assign outData  = state_q.mem[state_q.rd];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        state_d = state_q;
        if (push) begin
            state_d.mem[state_q.wr] = inData;
            state_d.wr = state_q.wr + 1'b1;
        end
        if (pop) begin
            state_d.rd = state_q.rd + 1'b1;
        end
        state_d.count = state_q.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule // pbm_fifo
`default_nettype wire

// file: rtl/pbm_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module pbm_sequencer (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // Configuration
    input  wire pbm_pkg::pbm_cfg_t cfg,
    input  wire logic [15:0]       addrLoad,
    input  wire logic              addrLoadStrobe,
    input  wire logic [7:0]        highByteWrite,
    input  wire logic              highByteStrobe,
    // Trigger access to the low data-in byte
    input  wire logic              trigValid,
    output logic                   trigReady,
    input  wire pbm_pkg::pbm_req_t trigReq,
    output logic [7:0]             trigReadData,
    // Status
    output logic                   busy,
    output logic                   cycleDone,
    output logic                   intPulse,
    output logic [15:0]            dataInReg,
    output logic [15:0]            addrReg,
    // Link pins
    input  wire logic [7:0]        dataPinsIn,
    output pbm_pkg::pbm_pins_t     pins,
    output logic                   chipSelectOne,
    output logic                   chipSelectTwo
);
    import pbm_pkg::*;

    typedef struct packed {
        pbm_state_t  st;
        logic        write;
        logic        second;
        logic [15:0] dataIn;
        logic [15:0] addr;
        logic [7:0]  lastRead;
        logic        done;
        logic        irq;
        pbm_pins_t   pins;
        logic        cs1;
        logic        cs2;
    } pbm_seq_t;

    pbm_seq_t   state_q, state_d;
    logic       fifoValid;
    logic       fifoReady;
    pbm_req_t   fifoReq;
    logic       acceptTrig;

    // Upper address byte with chip-select bits forced to zero
    function automatic logic [7:0] highAddr(input logic [15:0] a, input logic [1:0] csf);
        logic [7:0] h;
        h = a[15:8];
        if (csf == CS_ONE) begin
            h[7] = 1'b0;
        end else if (csf == CS_TWO) begin
            h[7:6] = 2'b00;
        end
        return h;
    endfunction

    // Busy trigger requests are dropped here, never queued
    assign acceptTrig = trigValid && !busy && cfg.masterMode;

    pbm_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .inValid  (acceptTrig),
        .inReady  (trigReady),
        .inData   (trigReq),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoReq)
    );

    assign fifoReady = (state_q.st == PBM_IDLE) && cfg.masterMode;

    always_comb begin
        logic lastCycle;
        logic startOp;
        logic [7:0] curByte;
        state_d = state_q;
        lastCycle = 1'b0;
        startOp = 1'b0;
        curByte = state_q.second ? state_q.dataIn[15:8] : state_q.dataIn[7:0];
        state_d.done = 1'b0;
        state_d.irq = 1'b0;
        if (addrLoadStrobe) begin
            state_d.addr = addrLoad;
        end
        if (highByteStrobe) begin
            state_d.dataIn[15:8] = highByteWrite;
        end
        // Default pin state between cycles
        state_d.pins.readStrobePin = 1'b0;
        state_d.pins.writeStrobePin = 1'b0;
        state_d.pins.byteEnableStrobe = 1'b0;
        state_d.pins.dataOe = 1'b0;
        state_d.cs1 = 1'b0;
        state_d.cs2 = 1'b0;
        unique case (state_q.st)
            PBM_IDLE: begin
                if (fifoValid && fifoReady) begin
                    startOp = 1'b1;
                    state_d.write = fifoReq.write;
                    state_d.second = 1'b0;
                    if (fifoReq.write) begin
                        state_d.dataIn[7:0] = fifoReq.data;
                    end else begin
                        state_d.lastRead = state_q.dataIn[7:0];
                    end
                end
            end
            PBM_ALOW: begin
                state_d.st = (cfg.addrMuxSelect == MUX_FULL) ? PBM_AHIGH : PBM_DATA;
            end
            PBM_AHIGH: begin
                state_d.st = PBM_DATA;
            end
            PBM_DATA: begin
                if (!state_q.write) begin
                    if (state_q.second) begin
                        state_d.dataIn[15:8] = dataPinsIn;
                    end else begin
                        state_d.dataIn[7:0] = dataPinsIn;
                    end
                end
                state_d.done = 1'b1;
                state_d.irq = cfg.intEnable;
                if (cfg.wideDataSelect && !state_q.second) begin
                    state_d.second = 1'b1;
                    startOp = 1'b1;
                end else begin
                    lastCycle = 1'b1;
                    state_d.st = PBM_IDLE;
                    unique case (cfg.addrStepSelect)
                        STEP_INC: state_d.addr = state_q.addr + 16'h0001;
                        STEP_DEC: state_d.addr = state_q.addr - 16'h0001;
                        default: state_d.addr = state_q.addr;
                    endcase
                end
            end
            default: state_d.st = PBM_IDLE;
        endcase
        if (startOp) begin
            state_d.st = (cfg.addrMuxSelect == MUX_NONE) ? PBM_DATA : PBM_ALOW;
        end
        // Drive pins for the phase being entered
        state_d.pins.addressPins = state_d.addr;
        state_d.pins.addressOe = 16'hFFFF;
        if (cfg.addrMuxSelect == MUX_PART) begin
            state_d.pins.addressOe[7:1] = 7'h00;
            state_d.pins.addressPins[0] = (state_d.st == PBM_ALOW);
        end else if (cfg.addrMuxSelect == MUX_FULL) begin
            state_d.pins.addressOe[13:2] = 12'h000;
            state_d.pins.addressPins[0] = (state_d.st == PBM_ALOW);
            state_d.pins.addressPins[1] = (state_d.st == PBM_AHIGH);
        end
        if (cfg.chipSelectFunction != CS_NONE) begin
            state_d.pins.addressOe[15] = 1'b0;
            state_d.cs2 = (state_d.st != PBM_IDLE) && state_d.addr[15];
        end
        if (cfg.chipSelectFunction == CS_TWO) begin
            state_d.pins.addressOe[14] = 1'b0;
            state_d.cs1 = (state_d.st != PBM_IDLE) && state_d.addr[14];
        end
        curByte = state_d.second ? state_d.dataIn[15:8] : state_d.dataIn[7:0];
        unique case (state_d.st)
            PBM_ALOW: begin
                state_d.pins.dataOut = state_d.addr[7:0];
                state_d.pins.dataOe = 1'b1;
            end
            PBM_AHIGH: begin
                state_d.pins.dataOut = highAddr(state_d.addr, cfg.chipSelectFunction);
                state_d.pins.dataOe = 1'b1;
            end
            PBM_DATA: begin
                state_d.pins.dataOut = curByte;
                state_d.pins.dataOe = state_d.write;
                if (cfg.sharedStrobe) begin
                    state_d.pins.readStrobePin = !state_d.write;
                    state_d.pins.writeStrobePin = 1'b1;
                end else begin
                    state_d.pins.readStrobePin = !state_d.write;
                    state_d.pins.writeStrobePin = state_d.write;
                end
                state_d.pins.byteEnableStrobe = state_d.second;
            end
            default: state_d.pins.dataOut = state_q.pins.dataOut;
        endcase
        state_d.pins.byteEnableOe = cfg.wideDataSelect;
        if (!cfg.masterMode) begin
            state_d.st = PBM_IDLE;
            state_d.pins.addressOe = 16'h0000;
            state_d.pins.dataOe = 1'b0;
            state_d.pins.readStrobePin = 1'b0;
            state_d.pins.writeStrobePin = 1'b0;
            state_d.pins.byteEnableOe = 1'b0;
        end
        if (lastCycle) begin
            state_d.second = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= '{st: PBM_IDLE, dataIn: DATA_RESET, addr: ADDR_RESET, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    // Busy covers all but the last cycle; single-cycle ops show it only while queued
    assign busy = cfg.masterMode && (fifoValid || (state_q.st != PBM_IDLE &&
                  !(state_q.st == PBM_DATA && !(cfg.wideDataSelect && !state_q.second))));
    assign cycleDone    = state_q.done;
    assign intPulse     = state_q.irq;
    assign trigReadData = state_q.lastRead;
    assign dataInReg    = state_q.dataIn;
    assign addrReg      = state_q.addr;
    assign pins         = state_q.pins;
    assign chipSelectOne = state_q.cs1;
    assign chipSelectTwo = state_q.cs2;
endmodule // pbm_sequencer
`default_nettype wire

// file: verification/pbm_sequencer_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pbm_sequencer_monitor
    import pbm_pkg::*;
(
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               reset,
    // Watched ports
    input wire pbm_pkg::pbm_cfg_t  cfg,
    input wire logic [15:0]        addrReg,
    input wire logic               addrLoadStrobe,
    input wire logic               busy,
    input wire logic               cycleDone,
    input wire logic               intPulse,
    input wire pbm_pkg::pbm_pins_t pins,
    input wire logic               chipSelectOne
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic lowLatch;
    logic highLatch;
    logic strobe;
    assign lowLatch  = pins.addressPins[0] && pins.addressOe[0] && cfg.addrMuxSelect != MUX_NONE;
    assign highLatch = pins.addressPins[1] && pins.addressOe[1] && cfg.addrMuxSelect == MUX_FULL;
    // Direction level on the read pin is no strobe in the shared scheme
    assign strobe = pins.writeStrobePin || (!cfg.sharedStrobe && pins.readStrobePin);

    a_int_on_done: assert property (intPulse |-> cycleDone && cfg.intEnable)
        else $error("interrupt without completed cycle");
    a_done_raises_int: assert property (cycleDone && cfg.intEnable |-> intPulse)
        else $error("completed cycle without interrupt");
    a_narrow_no_be: assert property ($stable(cfg) && !cfg.wideDataSelect |-> !pins.byteEnableOe)
        else $error("byte enable driven in 8-bit mode");
    a_cs_one_role: assert property ($stable(cfg) && chipSelectOne |-> cfg.chipSelectFunction == CS_TWO)
        else $error("first chip select active while it is an address pin");
    a_full_phases: assert property ($stable(cfg) && cfg.addrMuxSelect == MUX_FULL && lowLatch
        |=> highLatch ##1 strobe) else $error("full mux phase order broken");
    a_cs_bits_zero: assert property (highLatch && cfg.chipSelectFunction != CS_NONE
        |-> !pins.dataOut[7] && (cfg.chipSelectFunction != CS_TWO || !pins.dataOut[6]))
        else $error("chip select bits not zero in high phase");
    a_addr_held: assert property (!addrLoadStrobe && cfg.addrStepSelect == STEP_NONE
        |=> $stable(addrReg)) else $error("address moved without step or load");
    a_busy_bounded: assert property ($rose(busy) |-> ##[1:40] !busy)
        else $error("busy stuck high");
    c_full_mux: cover property (lowLatch ##1 highLatch);
    c_interrupt: cover property (intPulse);
    c_cs_active: cover property (chipSelectOne && strobe);
endmodule // pbm_sequencer_monitor
`default_nettype wire

// file: verification/pbm_ext_memory.sv
`timescale 1ns/10ps
`default_nettype none
module pbm_ext_memory
    import pbm_pkg::*;
(
    // Clock
    input wire logic               clk_sys,
    // Bus seen from the memory side
    input wire pbm_pkg::pbm_cfg_t  cfg,
    input wire pbm_pkg::pbm_pins_t pins,
    output logic [7:0]             dataPinsIn
);
    logic [7:0] mem [0:255];
    logic [7:0] latchLow = 8'h00;
    logic [7:0] lastOut = 8'h5A;
    logic [7:0] index;
    logic       act;
    assign act = cfg.sharedStrobe ? pins.writeStrobePin
        : (pins.readStrobePin || pins.writeStrobePin);
    assign index = {(cfg.addrMuxSelect == MUX_NONE) ? pins.addressPins[6:0] : latchLow[6:0],
        pins.byteEnableStrobe};
    // Released bus toggles so that a late sample can never look right
    assign dataPinsIn = (act && !pins.dataOe) ? mem[index] : ~lastOut;
    always @(posedge clk_sys) begin
        if (pins.addressPins[0] && pins.addressOe[0] && cfg.addrMuxSelect != MUX_NONE)
            latchLow <= pins.dataOut;
        if (act && pins.dataOe)
            mem[index] <= pins.dataOut;
        lastOut <= dataPinsIn;
    end
endmodule // pbm_ext_memory
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pbm_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    pbm_cfg_t    cfg = '0;
    logic [15:0] addrLoad = 16'h0000;
    logic [7:0]  highByteWrite = 8'h00;
    logic        addrLoadStrobe = 1'b0;
    logic        highByteStrobe = 1'b0;
    logic        trigValid = 1'b0;
    pbm_req_t    trigReq = '0;
    logic        trigReady, busy, cycleDone, intPulse, chipSelectOne, chipSelectTwo;
    logic [7:0]  trigReadData, dataPinsIn;
    logic [15:0] dataInReg, addrReg, addrA, addrB;
    pbm_pins_t   pins;
    logic [1:0]  csSeen;
    logic [7:0]  bytes [4];
    int          num_errors, comparisons, doneCnt, intCnt, seedDummy;

    pbm_sequencer u_dut (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .addrLoad(addrLoad),
        .addrLoadStrobe(addrLoadStrobe), .highByteWrite(highByteWrite),
        .highByteStrobe(highByteStrobe), .trigValid(trigValid), .trigReady(trigReady),
        .trigReq(trigReq), .trigReadData(trigReadData), .busy(busy), .cycleDone(cycleDone),
        .intPulse(intPulse), .dataInReg(dataInReg), .addrReg(addrReg),
        .dataPinsIn(dataPinsIn), .pins(pins), .chipSelectOne(chipSelectOne),
        .chipSelectTwo(chipSelectTwo));
    pbm_ext_memory u_memory (.clk_sys(clk_sys), .cfg(cfg), .pins(pins), .dataPinsIn(dataPinsIn));

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        doneCnt <= doneCnt + int'(cycleDone === 1'b1);
        intCnt <= intCnt + int'(intPulse === 1'b1);
        // Cleared by the address load that opens every access
        csSeen <= (addrLoadStrobe ? 2'h0 : csSeen) | {chipSelectTwo, chipSelectOne};
    end

    task automatic check(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One trigger access; extra retries the trigger while busy, which must be dropped
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] lo,
                          input logic [7:0] hi, input logic extra);
        int          d0;
        int          i0;
        int          n;
        logic [15:0] nb;
        logic [15:0] oe;
        d0 = doneCnt;
        i0 = intCnt;
        nb = (cfg.masterMode ? 16'h1 : 16'h0) << cfg.wideDataSelect;
        addrLoad = a;
        highByteWrite = hi;
        addrLoadStrobe = 1'b1;
        highByteStrobe = 1'b1;
        @(negedge clk_sys);
        addrLoadStrobe = 1'b0;
        highByteStrobe = 1'b0;
        trigReq = '{wr, lo};
        trigValid = 1'b1;
        @(negedge clk_sys);
        if (extra && busy === 1'b1) begin
            trigReq.data = ~lo;
            @(negedge clk_sys);
        end
        trigValid = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 40) begin
            num_errors++;
            $display("wrong value at %0t: busy never returned low", $time);
        end
        repeat (3) @(negedge clk_sys);
        check(16'(doneCnt - d0), nb);
        check(16'(intCnt - i0), cfg.intEnable ? nb : 16'h0);
        check({14'h0, csSeen}, {14'h0, nb != 0 && a[15] && cfg.chipSelectFunction != CS_NONE,
            nb != 0 && a[14] && cfg.chipSelectFunction == CS_TWO});
        // Pins that the mux and chip-select settings hand back as plain I/O
        oe = cfg.masterMode ? 16'hFFFF : 16'h0000;
        if (cfg.addrMuxSelect == MUX_PART) oe[7:1] = 7'h00;
        if (cfg.addrMuxSelect == MUX_FULL) oe[13:2] = 12'h000;
        if (cfg.chipSelectFunction != CS_NONE) oe[15] = 1'b0;
        if (cfg.chipSelectFunction == CS_TWO) oe[14] = 1'b0;
        check(pins.addressOe, oe);
        check({15'h0, pins.byteEnableOe}, {15'h0, cfg.masterMode && cfg.wideDataSelect});
        check({15'h0, trigReady}, 16'h0001);
    endtask

    initial begin
        seedDummy = $urandom(32'hDD828966);
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        for (int k = 0; k < 12; k++) begin
            cfg = '{1'b1, k[0], k[1], 2'(k / 4), 2'($urandom_range(2)), STEP_NONE, 1'($urandom)};
            addrA = 16'($urandom) & 16'hFFFD;
            addrB = addrA | 16'h0002;
            for (int j = 0; j < 4; j++) bytes[j] = 8'($urandom);
            access(1'b1, addrA, bytes[0], bytes[1], 1'b1);
            access(1'b1, addrB, bytes[2], bytes[3], 1'b0);
            access(1'b0, addrA, 8'h00, 8'h00, 1'b0);
            access(1'b0, addrB, 8'h00, 8'h00, 1'b0);
            check({8'h00, trigReadData}, {8'h00, bytes[0]});
            access(1'b0, addrB, 8'h00, 8'h00, 1'b0);
            check({8'h00, trigReadData}, {8'h00, bytes[2]});
            check(cfg.wideDataSelect ? dataInReg : {8'h00, dataInReg[7:0]},
                {cfg.wideDataSelect ? bytes[3] : 8'h00, bytes[2]});
            $display("test %0d ended, settings %b", k, cfg);
        end
        for (int k = 1; k < 3; k++) begin
            cfg = '{1'b1, 1'b0, 1'b0, MUX_NONE, CS_NONE, 2'(k), 1'b0};
            addrA = 16'($urandom);
            access(1'b1, addrA, 8'h3C, 8'h00, 1'b0);
            check(addrReg, k == 1 ? addrA + 16'h0001 : addrA - 16'h0001);
            $display("test step %0d ended", k);
        end
        cfg = '{1'b0, 1'b0, 1'b0, MUX_NONE, CS_NONE, STEP_NONE, 1'b1};
        access(1'b1, addrA, 8'hC3, 8'h00, 1'b0);
        $display("test slave ended");
        print_verdict();
    end

    // The tests need under 6000 cycles; this allows well over that
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end
endmodule // tb

bind pbm_sequencer pbm_sequencer_monitor u_monitor (.clk_sys(clk_sys), .reset(reset),
    .cfg(cfg), .addrReg(addrReg), .addrLoadStrobe(addrLoadStrobe), .busy(busy),
    .cycleDone(cycleDone), .intPulse(intPulse), .pins(pins), .chipSelectOne(chipSelectOne));
`default_nettype wire
